// *** design/pulse_params.svh ***
`ifndef PULSE_PARAMS_SVH
`define PULSE_PARAMS_SVH

// ----------------------------------------------------------------------------
// clocking
// ----------------------------------------------------------------------------
`define PW_SYS_CLK_MHZ 200
`define PW_TIMER_BASE_MHZ 16
`define PW_FINE_PER_TICK 2
// fine step = half a timer tick, so the accumulator adds twice the base rate
`define PW_FINE_INC_MHZ (`PW_TIMER_BASE_MHZ * `PW_FINE_PER_TICK)
`define PW_DIV4_LAST 4'h3
`define PW_DIV16_LAST 4'hF

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define PW_ADDR_PERIOD 12'h000
`define PW_ADDR_DUTY 12'h004
`define PW_ADDR_CTRL 12'h008
`define PW_ADDR_STATUS 12'h00C
`define PW_PERIOD_RST 16'h3F00
`define PW_DUTY_RST 16'h2000
`define PW_IMPL_MASK 16'hFF03

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PW_HI_MSB 15
`define PW_HI_LSB 8
`define PW_LO_MSB 1
`define PW_LO_LSB 0
`define PW_CTRL_EN_BIT 0
`define PW_ST_OUT_BIT 0
`define PW_ST_RUN_BIT 1
`define PW_ST_CNT_LSB 16
`define PW_ST_CNT_MSB 25

`endif

// *** design/pulse_pkg.sv ***
package pulse_pkg;

  typedef enum logic [1:0] {
    pre_div1 = 2'b00,
    pre_div4 = 2'b01,
    pre_div16 = 2'b10,
    pre_unused = 2'b11
  } prescale_t;

  // gray order: idle -> run
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run = 2'b01
  } gen_state_t;

endpackage : pulse_pkg

// *** design/pulse_step_gen.sv ***
`timescale 1ns/1ps
`include "pulse_params.svh"

module pulse_step_gen (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] pre_code_i,
  output logic step_o
);

  localparam logic [7:0] ACC_MOD = 8'(`PW_SYS_CLK_MHZ);
  localparam logic [7:0] FINE_INC = 8'(`PW_FINE_INC_MHZ);

  typedef struct packed {
    logic [7:0] acc;
    logic [3:0] pre_cnt;
    logic fine;
    logic step;
  } step_state_t;

  step_state_t s;
  step_state_t next_s;

  // last count of the prescale divider; the unused code falls back to 1:1
  function automatic logic [3:0] prescale_last(input logic [1:0] code);
    case (pulse_pkg::prescale_t'(code))
      pulse_pkg::pre_div4: prescale_last = `PW_DIV4_LAST;
      pulse_pkg::pre_div16: prescale_last = `PW_DIV16_LAST;
      default: prescale_last = 4'h0;
    endcase
  endfunction : prescale_last

  // ---------------------------------------------------------------------------
  // fractional base: 32 mhz half-ticks out of 200 mhz, jitter of one cycle
  // ---------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.fine = 1'b0;
    next_s.step = 1'b0;
    if (s.acc >= ACC_MOD - FINE_INC) begin
      next_s.acc = s.acc + FINE_INC - ACC_MOD;
      next_s.fine = 1'b1;
    end else begin
      next_s.acc = s.acc + FINE_INC;
    end
    // prescale restarts while stopped so a new frame begins aligned
    if (!run_i) begin
      next_s.pre_cnt = 4'h0;
    end else if (s.fine) begin
      if (s.pre_cnt >= prescale_last(pre_code_i)) begin
        next_s.pre_cnt = 4'h0;
        next_s.step = 1'b1;
      end else begin
        next_s.pre_cnt = s.pre_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign step_o = s.step;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  fine_spacing_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.fine |=> !s.fine [*5]) else $error("half-tick faster than 32 MHz");
  step_div16_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (run_i && pre_code_i == 2'b10 && s.step && $stable(pre_code_i)) |=> !s.step [*8])
    else $error("1:16 prescale stepped too soon");

endmodule : pulse_step_gen

// *** design/pulse_apb_regs.sv ***
`timescale 1ns/1ps
`include "pulse_params.svh"

module pulse_apb_regs (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic out_level_i,
  input wire logic running_i,
  input wire logic [9:0] count_i,
  output logic [7:0] period_val_o,
  output logic [1:0] pre_code_o,
  output logic [9:0] duty_val_o,
  output logic enable_o
);

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] duty;
    logic enable;
    logic [31:0] rdata;
    logic err;
  } reg_state_t;

  reg_state_t s;
  reg_state_t next_s;
  logic [31:0] status_word;

  // byte-lane merge limited to implemented bits; bits 7..2 stay zero
  function automatic logic [15:0] lane_write(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [15:0] v;
    v = old;
    if (strb[0]) v[7:0] = wd[7:0];
    if (strb[1]) v[15:8] = wd[15:8];
    lane_write = v & `PW_IMPL_MASK;
  endfunction : lane_write

  always_comb begin
    status_word = '0;
    status_word[`PW_ST_OUT_BIT] = out_level_i;
    status_word[`PW_ST_RUN_BIT] = running_i;
    status_word[`PW_ST_CNT_MSB:`PW_ST_CNT_LSB] = count_i;
  end

  // ---------------------------------------------------------------------------
  // read data is captured in setup, writes land at the access edge
  // ---------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (psel_i && !penable_i) begin
      next_s.err = 1'b0;
      next_s.rdata = '0;
      case (paddr_i)
        `PW_ADDR_PERIOD: next_s.rdata = {16'h0000, s.period};
        `PW_ADDR_DUTY: next_s.rdata = {16'h0000, s.duty};
        `PW_ADDR_CTRL: next_s.rdata = {31'h00000000, s.enable};
        `PW_ADDR_STATUS: next_s.rdata = status_word;
        default: next_s.err = 1'b1;
      endcase
    end
    if (psel_i && penable_i && pwrite_i) begin
      case (paddr_i)
        `PW_ADDR_PERIOD: next_s.period = lane_write(s.period, pwdata_i, pstrb_i);
        `PW_ADDR_DUTY: next_s.duty = lane_write(s.duty, pwdata_i, pstrb_i);
        `PW_ADDR_CTRL: if (pstrb_i[0]) next_s.enable = pwdata_i[`PW_CTRL_EN_BIT];
        default: next_s.err = s.err;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s.period <= `PW_PERIOD_RST;
      s.duty <= `PW_DUTY_RST;
      s.enable <= 1'b0;
      s.rdata <= '0;
      s.err <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign pready_o = psel_i & penable_i;  // zero wait states
  assign pslverr_o = psel_i & penable_i & s.err;
  assign prdata_o = s.rdata;
  assign period_val_o = s.period[`PW_HI_MSB:`PW_HI_LSB];
  assign pre_code_o = s.period[`PW_LO_MSB:`PW_LO_LSB];
  assign duty_val_o = {s.duty[`PW_HI_MSB:`PW_HI_LSB], s.duty[`PW_LO_MSB:`PW_LO_LSB]};
  assign enable_o = s.enable;

  reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (psel_i && !penable_i && (paddr_i == `PW_ADDR_PERIOD || paddr_i == `PW_ADDR_DUTY))
    |=> prdata_o[7:2] == 6'h00) else $error("reserved bits read nonzero");

endmodule : pulse_apb_regs

// *** design/pulse_output_gen.sv ***
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "pulse_params.svh"

// How it works
// - timer ticks at 16 MHz base
// - output driven only while enable bit set
// - period value bits 15-8, prescale 1-0
// - prescale codes: 1, 4, 16, unused
// - frame = (period+1) x 2 ticks x prescale
// - count match clears timer, sets output
// - zero duty keeps output low all frame
// - duty = bits 15-8 and bits 1-0
// - duty writes apply after current frame
// - duty double buffered with two-bit extension
// - high time = duty x half tick x prescale
// - duty beyond frame keeps output high
// - ten-bit resolution at full period
// - unimplemented bits read zero, ignore writes

module pulse_output_gen (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic pwm_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    pulse_pkg::gen_state_t state;
    logic [9:0] count;
    logic [9:0] active;
    logic out;
  } gen_t;

  gen_t s;
  gen_t next_s;
  logic [7:0] period_val;
  logic [1:0] pre_code;
  logic [9:0] duty_val;
  logic enable;
  logic step;
  logic [9:0] frame_last;
  logic frame_end;

  // ---------------------------------------------------------------------------
  // register file and step timing
  // ---------------------------------------------------------------------------
  pulse_apb_regs u_regs (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .paddr_i(paddr_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .out_level_i(s.out),
    .running_i(s.state == pulse_pkg::st_run),
    .count_i(s.count),
    .period_val_o(period_val),
    .pre_code_o(pre_code),
    .duty_val_o(duty_val),
    .enable_o(enable)
  );

  pulse_step_gen u_step (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(s.state == pulse_pkg::st_run),
    .pre_code_i(pre_code),
    .step_o(step)
  );

  // ---------------------------------------------------------------------------
  // frame timer
  // ---------------------------------------------------------------------------
  // the low two count bits are the half-tick extension beyond the 8-bit timer,
  // giving four compare steps per period unit and so ten bits of duty
  assign frame_last = {period_val, 2'b11};
  // >= rather than == so a period shrunk mid-frame still wraps at the next step
  assign frame_end = (s.count >= frame_last);

  always_comb begin
    next_s = s;
    case (s.state)
      pulse_pkg::st_idle: begin
        // held cleared; the buffer follows the register until the start
        next_s.count = '0;
        next_s.out = 1'b0;
        next_s.active = duty_val;
        if (enable) begin
          next_s.state = pulse_pkg::st_run;
          next_s.out = (duty_val != 10'h000);
        end
      end
      pulse_pkg::st_run: begin
        if (!enable) begin
          next_s.state = pulse_pkg::st_idle;
          next_s.count = '0;
          next_s.out = 1'b0;
        end else if (step) begin
          if (frame_end) begin
            next_s.count = '0;
            next_s.active = duty_val;
            next_s.out = (duty_val != 10'h000);
          end else begin
            next_s.count = s.count + 10'h001;
            // compare against the held copy only: no mid-frame glitch
            next_s.out = ((s.count + 10'h001) < s.active);
          end
        end
      end
      default: begin
        next_s.state = pulse_pkg::st_idle;
        next_s.count = '0;
        next_s.out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s.state <= pulse_pkg::st_idle;
      s.count <= '0;
      s.active <= '0;
      s.out <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign pwm_o = s.out;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  disabled_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !enable |=> !pwm_o) else $error("output high while disabled");
  timer_cleared_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.state == pulse_pkg::st_idle) |-> (s.count == 10'h000 && !pwm_o))
    else $error("timer not cleared while idle");
  frame_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (enable && s.state == pulse_pkg::st_run && step && frame_end)
    |=> (s.count == 10'h000 && pwm_o == (s.active != 10'h000)))
    else $error("frame did not restart on match");
  zero_duty_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.state == pulse_pkg::st_run && enable && s.active == 10'h000 && !frame_end)
    |=> !pwm_o) else $error("output high with zero duty");
  duty_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.state == pulse_pkg::st_run && enable && !(step && frame_end))
    |=> $stable(s.active)) else $error("duty changed inside a frame");
  over_duty_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.state == pulse_pkg::st_run && enable && pwm_o && s.active > frame_last && !frame_end
     && $stable(period_val)) |=> pwm_o) else $error("output cleared with duty past period");
  high_time_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.state == pulse_pkg::st_run && enable && step && !frame_end)
    |=> pwm_o == (s.count < s.active)) else $error("high time compare wrong");
  frame_count_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.state == pulse_pkg::st_run) |-> (s.count <= frame_last || $changed(period_val)
     || $past(s.count) >= frame_last)) else $error("timer ran past the frame");
  start_level_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(s.state == pulse_pkg::st_run) |-> s.count == 10'h000)
    else $error("frame did not start from zero");

  start_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(s.state == pulse_pkg::st_run));
  wrap_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    s.state == pulse_pkg::st_run && step && frame_end);
  fall_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $fell(pwm_o) && enable);
  full_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    s.active > frame_last && step && frame_end && pwm_o);

endmodule : pulse_output_gen

// *** test/pwm_load.sv ***
`timescale 1ns/1ps

// load on the pulse pin: times each high pulse and each frame in system clocks
module pwm_load (
  input wire logic sys_clk_i,
  input wire logic pwm_i,
  output int hi_o,
  output int per_o,
  output int rises_o,
  output int falls_o
);
  int cyc;
  int t_rise;
  logic last;

  initial begin
    {cyc, t_rise, hi_o, per_o, rises_o, falls_o} = '0;
    last = 1'b0;
  end

  // ------------------------------------------------------------
  // edge timing
  // ------------------------------------------------------------
  // a pure load: it never drives the pin, so it only measures
  always @(posedge sys_clk_i) begin
    cyc++;
    if (pwm_i === 1'b1 && last === 1'b0) begin
      per_o = cyc - t_rise;
      t_rise = cyc;
      rises_o++;
    end
    if (pwm_i === 1'b0 && last === 1'b1) begin
      hi_o = cyc - t_rise;
      falls_o++;
    end
    last = pwm_i;
  end
endmodule : pwm_load

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "pulse_params.svh"

module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] paddr_i = 12'h000;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic pwm_o;
  int hi, per, rises, falls;
  int fail_count = 0;
  int n_compared = 0;
  int tcyc = 0;
  logic [31:0] rdv;
  logic err;

  always #2.5 sys_clk_i = ~sys_clk_i;

  pulse_output_gen dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pwm_o(pwm_o));

  pwm_load load (.sys_clk_i(sys_clk_i), .pwm_i(pwm_o), .hi_o(hi), .per_o(per), .rises_o(rises),
    .falls_o(falls));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // tolerance covers the 6/7 clock jitter of the half-tick strobe
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol);
    int d;
    d = int'(got) - int'(exp);
    n_compared++;
    if (got !== exp && (tol == 0 || $isunknown(got) || d > tol || d < -tol)) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is seen at an edge
  // only the global hang guard ends a wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rdv = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv, exp, 0);
  endtask : rdchk

  // bounded wait for the load to see another edge
  task automatic wait_chg(ref int v);
    int v0;
    int n;
    v0 = v;
    n = 0;
    while (v == v0 && n < 2000) begin
      @(posedge sys_clk_i);
      n++;
    end
    // a missing edge is a failure, not a silent fall-through
    if (v == v0) begin
      fail_count++;
      $display("Error at %0t: no pulse edge seen", $time);
    end
  endtask : wait_chg

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic run_frame(input logic [7:0] p, input logic [1:0] code, input int f, input logic [9:0] dt);
    int fr;
    fr = 25 * (int'(p) + 1) * f;
    apb(1'b1, `PW_ADDR_PERIOD, {16'h0, p, 6'h00, code});
    apb(1'b1, `PW_ADDR_DUTY, {16'h0, dt[9:2], 6'h00, dt[1:0]});
    apb(1'b1, `PW_ADDR_CTRL, 32'h1);
    repeat (3 * fr + 20) @(posedge sys_clk_i);
    check(per, fr, 2);
    check(hi, (int'(dt) * f * 25) / 4, 2);
    apb(1'b1, `PW_ADDR_CTRL, 32'h0);
  endtask : run_frame

  task automatic edge_duty;
    int r0;
    apb(1'b1, `PW_ADDR_PERIOD, 32'h0300);
    apb(1'b1, `PW_ADDR_DUTY, 32'h0);
    r0 = rises;
    apb(1'b1, `PW_ADDR_CTRL, 32'h1);
    repeat (300) @(posedge sys_clk_i);
    check(rises - r0, 0, 0);
    // duty beyond the frame: pin never falls
    apb(1'b1, `PW_ADDR_DUTY, 32'hFF03);
    repeat (300) @(posedge sys_clk_i);
    r0 = falls;
    repeat (300) @(posedge sys_clk_i);
    check(falls - r0, 0, 0);
    check(pwm_o, 1, 0);
    apb(1'b0, `PW_ADDR_STATUS, 32'h0);
    check(rdv[1:0], 2'b11, 0);
    apb(1'b1, `PW_ADDR_CTRL, 32'h0);
    @(posedge sys_clk_i);
    #1;
    check(pwm_o, 0, 0);
  endtask : edge_duty

  // duty rewritten inside a high pulse only shows in the next frame
  task automatic dbuf;
    apb(1'b1, `PW_ADDR_PERIOD, 32'h0300);
    apb(1'b1, `PW_ADDR_DUTY, 32'h0200);
    apb(1'b1, `PW_ADDR_CTRL, 32'h1);
    repeat (250) @(posedge sys_clk_i);
    wait_chg(rises);
    apb(1'b1, `PW_ADDR_DUTY, 32'h0100);
    wait_chg(falls);
    check(hi, 50, 2);
    wait_chg(falls);
    check(hi, 25, 2);
    apb(1'b1, `PW_ADDR_CTRL, 32'h0);
  endtask : dbuf

  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    tcyc++;
    if (tcyc == 60000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    int r0;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    check(pwm_o, 0, 0);
    rdchk(`PW_ADDR_PERIOD, 32'h3F00);
    rdchk(`PW_ADDR_DUTY, 32'h2000);
    rdchk(`PW_ADDR_CTRL, 32'h0);
    rdchk(`PW_ADDR_STATUS, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1, 0);
    check(rdv, 0, 0);
    apb(1'b1, `PW_ADDR_PERIOD, 32'hFFFF);
    rdchk(`PW_ADDR_PERIOD, 32'hFF03);
    apb(1'b1, `PW_ADDR_DUTY, 32'hFFFF);
    rdchk(`PW_ADDR_DUTY, 32'hFF03);
    r0 = rises;
    repeat (200) @(posedge sys_clk_i);
    check(rises - r0, 0, 0);
    run_frame(8'h03, 2'b00, 1, 10'd5);
    run_frame(8'h03, 2'b01, 4, 10'd6);
    run_frame(8'h03, 2'b11, 1, 10'd5);
    run_frame(8'h01, 2'b10, 16, 10'd3);
    edge_duty();
    dbuf();
    final_report();
  end
endmodule : tb_top
